//--- design/pif_pkg.sv
`default_nettype none
package pif_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] FLAGS_OFFSET   = 8'h10;
    localparam logic [7:0] ENABLE_OFFSET  = 8'h14;
    localparam logic [7:0] CLEAR_OFFSET   = 8'h18;
    localparam logic [7:0] PENDING_OFFSET = 8'h1C;
    localparam int SYNC_SERIAL_BIT   = 7;
    localparam int BUS_COLL_BIT      = 6;
    localparam int CONV_DONE_BIT     = 5;
    localparam int UNUSED_BIT        = 4;
    localparam int CAPTURE_FOUR_BIT  = 3;
    localparam int CAPTURE_THREE_BIT = 2;
    localparam int TX_EMPTY_BIT      = 1;
    localparam int RX_FULL_BIT       = 0;
    localparam logic [7:0] FLAGS_RESET    = 8'h02;
    localparam logic [7:0] WRITABLE_MASK  = 8'hEC;
    localparam logic [7:0] ENABLE_RESET   = 8'h00;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ****************************************************************
    // Peripheral event strobes and levels
    // ****************************************************************
    typedef struct packed {
        logic serialXferDone;
        logic masterSeqDone;
        logic idleStartStop;
        logic busCollision;
        logic convDone;
        logic captureFour;
        logic captureThree;
        logic txBufEmpty;
        logic rxBufFull;
    } pif_events_s;
endpackage
`default_nettype wire

//--- design/pif_flag_reg.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Serial port flag bit 7 sets on SPI or I2C transfer completion.
// - I2C master start, stop, restart or acknowledge completion sets bit 7.
// - Start or stop seen while serial port idle sets bit 7.
// - Bus collision in I2C master mode sets bit 6.
// - Conversion complete sets bit 5.
// - Bit 4 unimplemented, always reads zero.
// - Capture four pin event sets bit 3.
// - Capture three pin event sets bit 2.
// - Bit 1 follows transmit buffer empty, hardware controlled.
// - Bit 0 follows receive buffer full, hardware controlled.
// - Reset value 0x02; bits 1,0 read-only, 7,6,5,3,2 writable.
module pif_flag_reg (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                clkEn,
    // Peripheral events
    input  wire pif_pkg::pif_events_s events,
    // AXI4-Lite write address and data
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [7:0]          awaddr,
    input  wire logic                wvalid,
    output logic                     wready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    // AXI4-Lite write response
    output logic                     bvalid,
    input  wire logic                bready,
    output logic [1:0]               bresp,
    // AXI4-Lite read
    input  wire logic                arvalid,
    output logic                     arready,
    input  wire logic [7:0]          araddr,
    output logic                     rvalid,
    input  wire logic                rready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    // Interrupt
    output logic                     irq
);
    // ****************************************************************
    // Event collection
    // ****************************************************************
    logic [7:0] setEv;
    logic [7:0] flags_q, flags_d;
    logic [7:0] enable_q, enable_d;
    logic       awHeld_q, awHeld_d;
    logic       wHeld_q, wHeld_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic       wLow_q, wLow_d;
    logic       bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic       rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic       doWrite;
    logic [7:0] wrByte;
    logic       awHave;
    logic       wHave;
    logic [7:0] wrAddr;
    logic       wrLow;
    logic [7:0] pending;

    always_comb begin
        setEv = 8'h00;
        setEv[pif_pkg::SYNC_SERIAL_BIT] = events.serialXferDone
                                        | events.masterSeqDone
                                        | events.idleStartStop;
        setEv[pif_pkg::BUS_COLL_BIT]      = events.busCollision;
        setEv[pif_pkg::CONV_DONE_BIT]     = events.convDone;
        setEv[pif_pkg::CAPTURE_FOUR_BIT]  = events.captureFour;
        setEv[pif_pkg::CAPTURE_THREE_BIT] = events.captureThree;
    end

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Address and data are latched independently, so either order works
    // Readies drop while frozen, otherwise a master could hand over a word that is never stored
    assign awready = clkEn && !awHeld_q && !bvalid_q;
    assign wready  = clkEn && !wHeld_q && !bvalid_q;
    assign arready = clkEn && !rvalid_q;
    // Built from the registers and the live handshake, never from the next-state values,
    // so the write decode has no combinational loop through the bus process
    assign awHave  = awHeld_q || (awvalid && awready);
    assign wHave   = wHeld_q || (wvalid && wready);
    assign doWrite = awHave && wHave && !bvalid_q;
    assign wrAddr  = awHeld_q ? awAddr_q : awaddr;
    assign wrByte  = wHeld_q ? wData_q[7:0] : wdata[7:0];
    assign wrLow   = wHeld_q ? wLow_q : wstrb[0];

    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d  = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d  = wData_q;
        wLow_d   = wLow_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        if (awvalid && awready) begin
            awHeld_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && wready) begin
            wHeld_d = 1'b1;
            wData_d = wdata;
            wLow_d  = wstrb[0];
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d  = 1'b0;
            bvalid_d = 1'b1;
            case (wrAddr)
                pif_pkg::FLAGS_OFFSET,
                pif_pkg::ENABLE_OFFSET,
                pif_pkg::CLEAR_OFFSET: bresp_d = pif_pkg::RESP_OKAY;
                default:               bresp_d = pif_pkg::RESP_SLVERR;
            endcase
        end
    end

    // ****************************************************************
    // Flag and enable registers
    // ****************************************************************
    // Flag and clear writes only reach the writable bits; a set in the same cycle still wins
    always_comb begin
        flags_d  = flags_q;
        enable_d = enable_q;
        if (doWrite && wrLow) begin
            case (wrAddr)
                pif_pkg::FLAGS_OFFSET: begin
                    flags_d = (flags_q & ~pif_pkg::WRITABLE_MASK)
                            | (wrByte & pif_pkg::WRITABLE_MASK);
                end
                pif_pkg::CLEAR_OFFSET: begin
                    flags_d = flags_q & ~(wrByte & pif_pkg::WRITABLE_MASK);
                end
                pif_pkg::ENABLE_OFFSET: begin
                    enable_d = wrByte & ~(8'h01 << pif_pkg::UNUSED_BIT);
                end
                default: begin
                    flags_d = flags_q;
                end
            endcase
        end
        flags_d = flags_d | setEv;
        flags_d[pif_pkg::UNUSED_BIT]   = 1'b0;
        flags_d[pif_pkg::TX_EMPTY_BIT] = events.txBufEmpty;
        flags_d[pif_pkg::RX_FULL_BIT]  = events.rxBufFull;
    end

    assign pending = flags_q & enable_q;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d  = pif_pkg::RESP_OKAY;
            case (araddr)
                pif_pkg::FLAGS_OFFSET:   rdata_d = {24'h000000, flags_q};
                pif_pkg::ENABLE_OFFSET:  rdata_d = {24'h000000, enable_q};
                pif_pkg::CLEAR_OFFSET:   rdata_d = 32'h00000000;
                pif_pkg::PENDING_OFFSET: rdata_d = {24'h000000, pending};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = pif_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags_q  <= pif_pkg::FLAGS_RESET;
            enable_q <= pif_pkg::ENABLE_RESET;
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h00000000;
            wLow_q   <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= 2'h0;
        end else if (clkEn) begin
            flags_q  <= flags_d;
            enable_q <= enable_d;
            awHeld_q <= awHeld_d;
            wHeld_q  <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q  <= wData_d;
            wLow_q   <= wLow_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;
    assign irq    = |pending;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    serial_set_a: assert property (clkEn && events.serialXferDone |=> flags_q[7])
        else $error("serial flag not set");
    master_seq_a: assert property (clkEn && events.masterSeqDone |=> flags_q[7])
        else $error("master sequence flag not set");
    idle_cond_a: assert property (clkEn && events.idleStartStop |=> flags_q[7])
        else $error("idle start stop flag not set");
    serial_hold_a: assert property (flags_q[7] && !(doWrite && clkEn) |=> flags_q[7])
        else $error("serial flag cleared by hardware");
    collision_set_a: assert property (clkEn && events.busCollision |=> flags_q[6])
        else $error("collision flag not set");
    conv_set_a: assert property (clkEn && events.convDone |=> flags_q[5])
        else $error("conversion flag not set");
    unused_zero_a: assert property (flags_q[4] == 1'b0 && enable_q[4] == 1'b0)
        else $error("unused bit set");
    cap_four_a: assert property (clkEn && events.captureFour |=> flags_q[3])
        else $error("capture four flag not set");
    cap_three_a: assert property (clkEn && events.captureThree |=> flags_q[2])
        else $error("capture three flag not set");
    tx_follow_a: assert property (clkEn |=> flags_q[1] == $past(events.txBufEmpty))
        else $error("tx empty bit wrong");
    rx_follow_a: assert property (clkEn |=> flags_q[0] == $past(events.rxBufFull))
        else $error("rx full bit wrong");
    set_wins_a: assert property (clkEn && doWrite && setEv[2] |=> flags_q[2])
        else $error("set lost to clear");
    irq_level_a: assert property (irq == |(flags_q & enable_q))
        else $error("irq mismatch");
    irq_idle_a: assert property (enable_q == 8'h00 |-> !irq)
        else $error("irq raised with every source masked");

    // ****************************************************************
    // Bus checks
    // ****************************************************************
    // A stalled master must see the same answer on every cycle that it waits
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response changed before taken");
    rdata_hold_a: assert property (rvalid && !rready
        |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response changed before taken");
    write_answer_a: assert property (clkEn && doWrite |=> bvalid)
        else $error("write not answered");
    write_quiet_a: assert property (!bvalid && !(clkEn && doWrite) |=> !bvalid)
        else $error("write answer without a write");
    read_answer_a: assert property (clkEn && arvalid && arready |=> rvalid)
        else $error("read not answered");
    read_quiet_a: assert property (!rvalid && !(clkEn && arvalid && arready) |=> !rvalid)
        else $error("read answer without a read");
    busy_stall_a: assert property (bvalid |-> !awready && !wready)
        else $error("write channel open while a response waits");
    // Frozen means deaf as well: nothing may be accepted and then dropped
    freeze_ready_a: assert property (!clkEn |-> !awready && !wready && !arready)
        else $error("handshake accepted while frozen");
    freeze_state_a: assert property (!clkEn |=> $stable(flags_q) && $stable(enable_q))
        else $error("state moved while frozen");
    write_ok_a: assert property (clkEn && doWrite && wrAddr == pif_pkg::CLEAR_OFFSET
        |=> bresp == pif_pkg::RESP_OKAY)
        else $error("clear write refused");
    write_err_a: assert property (clkEn && doWrite && wrAddr != pif_pkg::FLAGS_OFFSET
        && wrAddr != pif_pkg::ENABLE_OFFSET && wrAddr != pif_pkg::CLEAR_OFFSET
        |=> bresp == pif_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    read_err_a: assert property (clkEn && arvalid && arready && araddr != pif_pkg::FLAGS_OFFSET
        && araddr != pif_pkg::ENABLE_OFFSET && araddr != pif_pkg::CLEAR_OFFSET
        && araddr != pif_pkg::PENDING_OFFSET |=> rresp == pif_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    rdata_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    unused_read_a: assert property (rvalid |-> rdata[pif_pkg::UNUSED_BIT] == 1'b0)
        else $error("unused bit read as one");

    // ****************************************************************
    // Flag checks
    // ****************************************************************
    // Writable flags move only by an event or by a write with the low strobe
    flag_sticky_a: assert property (clkEn && !(doWrite && wrLow)
        |=> (flags_q & pif_pkg::WRITABLE_MASK)
            == ($past(flags_q | setEv) & pif_pkg::WRITABLE_MASK))
        else $error("flag changed without event or write");
    direct_write_a: assert property (clkEn && doWrite && wrLow
        && wrAddr == pif_pkg::FLAGS_OFFSET
        |=> (flags_q & pif_pkg::WRITABLE_MASK)
            == ($past(wrByte | setEv) & pif_pkg::WRITABLE_MASK))
        else $error("direct flag write wrong");
    clear_write_a: assert property (clkEn && doWrite && wrLow
        && wrAddr == pif_pkg::CLEAR_OFFSET
        |=> (flags_q & $past(wrByte & pif_pkg::WRITABLE_MASK & ~setEv)) == 8'h00)
        else $error("clear register left a flag set");
    enable_write_a: assert property (clkEn && doWrite && wrLow
        && wrAddr == pif_pkg::ENABLE_OFFSET
        |=> enable_q == {$past(wrByte[7:5]), 1'b0, $past(wrByte[3:0])})
        else $error("enable write wrong");
    flag_read_a: assert property (clkEn && arvalid && arready
        && araddr == pif_pkg::FLAGS_OFFSET |=> rdata[7:0] == $past(flags_q))
        else $error("flag read returned a stale value");
    pending_read_a: assert property (clkEn && arvalid && arready
        && araddr == pif_pkg::PENDING_OFFSET |=> rdata[7:0] == $past(flags_q & enable_q))
        else $error("pending read wrong");
    // One check per writable flag: an event is never lost, whatever the bus does
    for (genvar i = 0; i < 8; i++) begin : g_setWins
        if (pif_pkg::WRITABLE_MASK[i]) begin : g_bit
            bit_set_wins_a: assert property (@(posedge clk) disable iff (reset)
                clkEn && setEv[i] |=> flags_q[i])
                else $error("event lost on a writable flag");
        end
    end

    // ****************************************************************
    // Coverage
    // ****************************************************************
    write_cov: cover property (doWrite && clkEn);
    read_cov: cover property (rvalid && rready);
    irq_cov: cover property (irq);
    clash_cov: cover property (clkEn && doWrite && wrLow && (setEv != 8'h00));
    freeze_cov: cover property (!clkEn && (setEv != 8'h00));
endmodule
`default_nettype wire

//--- sim/pif_periph_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Peripheral side: one-clock strobes and buffer levels
// ****
module pif_periph_model (
    input  wire logic                 clk,
    output wire pif_pkg::pif_events_s events
);
    logic [6:0] pulseQ = 7'h00;
    logic       txQ    = 1'b1;
    logic       rxQ    = 1'b0;
    assign events = {pulseQ, txQ, rxQ};
    // Strobes never stretch: a held strobe would hide a lost set
    task automatic pulse(input logic [6:0] p);
        @(posedge clk);
        pulseQ <= p;
        @(posedge clk);
        pulseQ <= 7'h00;
    endtask
    task automatic level(input logic tx, input logic rx);
        @(posedge clk);
        txQ <= tx;
        rxQ <= rx;
    endtask
endmodule
`default_nettype wire

//--- sim/test_peripheral_irq_flag_reg2.sv
`timescale 1ns/1ns
`default_nettype none
module test_peripheral_irq_flag_reg2;
    logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdD;
    logic [1:0] bresp, rresp, rsp;
    int err_total = 0, comparisons = 0;
    pif_pkg::pif_events_s events;
    pif_periph_model pm (.clk(clk), .events(events));
    pif_flag_reg dut (.clk(clk), .reset(reset), .clkEn(clkEn), .events(events),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
    // ****
    // Bus tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdD = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdD, e);
        chk({30'h0, rsp}, {30'h0, pif_pkg::RESP_OKAY});
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_events;
        int b[7] = '{7, 7, 7, 6, 5, 3, 2};
        for (int i = 0; i < 7; i++) begin
            pm.pulse(7'h40 >> i);
            rdChk(pif_pkg::FLAGS_OFFSET, 32'h02 | (32'h1 << b[i]));
            chk({31'h0, irq}, 32'h0);
            wr(pif_pkg::FLAGS_OFFSET, 32'h02);
            rdChk(pif_pkg::FLAGS_OFFSET, 32'h02);
        end
    endtask
    task automatic t_misc;
        pm.level(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        rdChk(pif_pkg::FLAGS_OFFSET, 32'h01);
        pm.level(1'b1, 1'b0);
        wr(pif_pkg::FLAGS_OFFSET, 32'hFFFFFFFF);
        rdChk(pif_pkg::FLAGS_OFFSET, 32'hEE);
        // Clear and event on one edge: the event must survive
        fork
            wr(pif_pkg::FLAGS_OFFSET, 32'h0);
            pm.pulse(7'h04);
        join
        rdChk(pif_pkg::FLAGS_OFFSET, 32'h22);
    endtask
    task automatic t_irq;
        wr(pif_pkg::ENABLE_OFFSET, 32'h20);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rdChk(pif_pkg::PENDING_OFFSET, 32'h20);
        wr(pif_pkg::CLEAR_OFFSET, 32'h20);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdChk(pif_pkg::FLAGS_OFFSET, 32'h02);
        rd(8'h40);
        chk({30'h0, rsp}, {30'h0, pif_pkg::RESP_SLVERR});
        chk(rdD, 32'h0);
        wr(8'h40, 32'hFF);
        chk({30'h0, rsp}, {30'h0, pif_pkg::RESP_SLVERR});
    endtask
    task automatic t_freeze;
        // An event in a frozen cycle is lost, not queued
        @(posedge clk);
        clkEn <= 1'b0;
        pm.pulse(7'h01);
        @(posedge clk);
        clkEn <= 1'b1;
        rdChk(pif_pkg::FLAGS_OFFSET, 32'h02);
    endtask
    task automatic t_reset;
        wr(pif_pkg::ENABLE_OFFSET, 32'hFF);
        pm.pulse(7'h7F);
        rdChk(pif_pkg::FLAGS_OFFSET, 32'hEE);
        chk({31'h0, irq}, 32'h1);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdChk(pif_pkg::FLAGS_OFFSET, 32'h02);
        rdChk(pif_pkg::ENABLE_OFFSET, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdChk(pif_pkg::FLAGS_OFFSET, 32'h02);
        rdChk(pif_pkg::ENABLE_OFFSET, 32'h0);
        t_events();
        t_misc();
        t_irq();
        t_freeze();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
